// >>> jet_cluster_pkg.sv
/*
  jet_cluster_pkg: constants, register map and enumerations shared by the jet cluster finder.
  Assumes it is compiled before any file that names it; nothing is imported anywhere.
*/
`default_nettype none
package jet_cluster_pkg;
  // ==========================================================================
  // element array geometry
  localparam int ROWS = 7;
  localparam int COLS = 11;
  localparam int NUM_ELEM = 77;
  localparam int HALF_W = 5;
  localparam int ELEM_W = 10;
  localparam int SUM_W = 14;
  localparam int S2_ROWS = 6;
  localparam int S2_COLS = 10;
  localparam int NUM_ROI = 8;
  localparam int NUM_CENT_CRIT = 8;
  localparam int NUM_FWD_CRIT = 4;
  localparam logic [3:0] CENT_LO_COL = 4'h1;
  localparam logic [3:0] CENT_HI_COL = 4'h8;
  localparam logic [9:0] ELEM_SAT = 10'h3FF;
  localparam logic [13:0] SUM_SAT = 14'h3FFF;
  localparam logic [9:0] THR_OFF = 10'h3FF;
  // ==========================================================================
  // result formats
  localparam int RESULT_W = 25;
  localparam int ROI_REC_W = 11;
  localparam int STREAM_LEN = 45;
  localparam logic [5:0] STREAM_LAST = 6'h2C;
  localparam logic [2:0] MULT_CENT_MAX = 3'h7;
  localparam logic [2:0] MULT_FWD_MAX = 3'h3;
  // ==========================================================================
  // register map (word index on reg_addr)
  localparam logic [4:0] ADDR_CRIT0 = 5'h00;
  localparam logic [4:0] ADDR_CTRL = 5'h0C;
  localparam logic [4:0] ADDR_STATUS = 5'h0D;
  localparam int CRIT_W = 12;
  localparam int THR_LSB = 0;
  localparam int SIZE_LSB = 10;
  localparam logic [11:0] CRIT_RST = 12'h3FF;
  localparam int CTRL_FWD_MOD = 0;
  localparam int CTRL_FWD_HI = 1;
  localparam int CTRL_SPLIT = 2;
  localparam logic [2:0] CTRL_RST = 3'h0;
  // ==========================================================================
  // enumerations
  typedef enum logic [1:0] {SIZE_2X2, SIZE_3X3, SIZE_4X4, SIZE_NONE} cluster_size_t;
  typedef enum logic {RO_IDLE, RO_SHIFT} ro_state_t;
endpackage
`default_nettype wire

// >>> jet_cluster_finder.sv
/*
  jet_cluster_finder: jet cluster algorithm with forward channel rearrangement, multiplicity
  word for the crate merger and serial region_of_interest readout streams.
  Assumes clk is the double-rate element clock, elem_hi_phase marks the cycle carrying the
  high halves, and all inputs are synchronous to clk.
*/
// What this block does
// - accept 77 jet elements per crossing
// - sixty 2x2 sums, local maximum vs neighbours
// - 3x3 and 4x4 sums formed alongside
// - per 2x2 subregion: position, cluster thresholds
// - eight central, four forward programmable criteria
// - 2x2 or 4x4: single comparison
// - 3x3: any of four clusters passes
// - forward element in maximum picks forward criteria
// - element at 0x3FF flags cluster saturated
// - threshold 0x3FF disables that criterion
// - central: eight 3-bit multiplicities, clamp 7
// - forward: 2-bit multiplicities, clamp 3
// - record: position, eight hit bits, saturation
// - four identical streams, two central, two forward
// - split forward value into unconnected neighbour
// - control bits steer forward rerouting multiplexers
// - results registered at bunch rate
// - merger word at most 25 bits with parity
// - element is 10-bit saturated energy
// - 5-bit halves, low first, reassembled
`default_nettype none
module jet_cluster_finder (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [384:0] elem_in,
  input wire logic elem_hi_phase,
  input wire logic roi_read,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  output logic [24:0] merger_word,
  output logic merger_valid,
  output logic [3:0] roi_stream,
  output logic roi_stream_valid
);
  // ==========================================================================
  // functions
  // window sum of n x n elements; any saturated element forces full scale
  function automatic logic [13:0] win_sum(input logic [769:0] e, input int r0, input int c0,
                                          input int n);
    logic [13:0] acc;
    logic sat;
    logic [9:0] v;
    acc = '0;
    sat = 1'b0;
    v = '0;
    for (int dr = 0; dr < 4; dr++)
      for (int dc = 0; dc < 4; dc++)
        if (dr < n && dc < n)
        begin
          v = e[((r0 + dr) * jet_cluster_pkg::COLS + c0 + dc) * jet_cluster_pkg::ELEM_W +: 10];
          acc = acc + 14'(v);
          sat = sat | (v == jet_cluster_pkg::ELEM_SAT);
        end
    win_sum = sat ? jet_cluster_pkg::SUM_SAT : acc;
  endfunction

  // ties broken by position so that exactly one of two equal neighbours wins
  function automatic logic is_lmax(input logic [839:0] s, input int r, input int c);
    logic ok;
    logic [13:0] v;
    logic [13:0] nb;
    ok = 1'b1;
    v = s[(r * jet_cluster_pkg::S2_COLS + c) * jet_cluster_pkg::SUM_W +: 14];
    nb = '0;
    for (int dr = -1; dr <= 1; dr++)
      for (int dc = -1; dc <= 1; dc++)
        if (dr != 0 || dc != 0)
        begin
          nb = s[((r + dr) * jet_cluster_pkg::S2_COLS + c + dc) * jet_cluster_pkg::SUM_W +: 14];
          if (dr < 0 || (dr == 0 && dc < 0))
            ok = ok & (v >= nb);
          else
            ok = ok & (v > nb);
        end
    is_lmax = ok;
  endfunction

  // one criterion against the clusters of one position
  function automatic logic crit_pass(input logic [11:0] crit, input logic [13:0] c2,
                                     input logic [55:0] c3, input logic [13:0] c4);
    logic [13:0] thr;
    logic any3;
    thr = 14'(crit[jet_cluster_pkg::THR_LSB +: 10]);
    any3 = 1'b0;
    for (int k = 0; k < 4; k++)
      any3 = any3 | (c3[k * 14 +: 14] > thr);
    case (jet_cluster_pkg::cluster_size_t'(crit[jet_cluster_pkg::SIZE_LSB +: 2]))
      jet_cluster_pkg::SIZE_2X2: crit_pass = c2 > thr;
      jet_cluster_pkg::SIZE_3X3: crit_pass = any3;
      jet_cluster_pkg::SIZE_4X4: crit_pass = c4 > thr;
      default: crit_pass = 1'b0;
    endcase
    if (crit[jet_cluster_pkg::THR_LSB +: 10] == jet_cluster_pkg::THR_OFF)
      crit_pass = 1'b0;
  endfunction

  // saturating population count
  function automatic logic [2:0] mult(input logic [7:0] bits, input logic [2:0] lim);
    logic [3:0] cnt;
    cnt = '0;
    for (int k = 0; k < 8; k++)
      cnt = cnt + 4'(bits[k]);
    mult = (cnt > 4'(lim)) ? lim : cnt[2:0];
  endfunction

  // ==========================================================================
  // registers and control
  logic [11:0] crit_r [12];
  logic [2:0] ctrl_r;
  logic [15:0] reg_rdata_r;
  logic [15:0] reg_rdata_nxt;
  logic [384:0] lo_r;
  logic [769:0] elem_r;
  logic [769:0] elem_nxt;
  logic bunch_r;
  logic [24:0] merger_word_r;
  logic merger_valid_r;
  logic [87:0] cent_rec_r;
  logic [87:0] fwd_rec_r;
  logic [7:0] found_r;
  logic sat_any_r;
  jet_cluster_pkg::ro_state_t ro_state_r;
  logic [5:0] ro_cnt_r;
  logic [44:0] sh_r [4];
  logic [3:0] roi_stream_r;
  logic roi_stream_valid_r;

  wire fwd_mod = ctrl_r[jet_cluster_pkg::CTRL_FWD_MOD];
  wire split_en = ctrl_r[jet_cluster_pkg::CTRL_SPLIT];
  // forward column selector: the rerouting multiplexer select
  wire [3:0] fwd_col = ctrl_r[jet_cluster_pkg::CTRL_FWD_HI] ? jet_cluster_pkg::CENT_HI_COL :
                       jet_cluster_pkg::CENT_LO_COL;

  // register decode
  wire crit_hit = reg_addr < jet_cluster_pkg::ADDR_CTRL;
  wire [3:0] crit_idx = reg_addr[3:0];
  wire ctrl_hit = reg_addr == jet_cluster_pkg::ADDR_CTRL;
  wire status_hit = reg_addr == jet_cluster_pkg::ADDR_STATUS;
  wire [15:0] status_word = {ro_state_r == jet_cluster_pkg::RO_SHIFT, sat_any_r, 6'h00, found_r};

  // read data only in the cycle after the strobe, zero otherwise
  assign reg_rdata_nxt = !reg_rd ? 16'h0000 :
                         crit_hit ? {4'h0, crit_r[crit_idx]} :
                         ctrl_hit ? {13'h0000, ctrl_r} :
                         status_hit ? status_word : 16'h0000;

  // criteria and control writes; status and unmapped writes are dropped
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      for (int k = 0; k < 12; k++)
        crit_r[k] <= jet_cluster_pkg::CRIT_RST;
      ctrl_r <= jet_cluster_pkg::CTRL_RST;
      reg_rdata_r <= 16'h0000;
    end
    else
    begin
      if (reg_wr && crit_hit)
        crit_r[crit_idx] <= reg_wdata[11:0];
      if (reg_wr && ctrl_hit)
        ctrl_r <= reg_wdata[2:0];
      reg_rdata_r <= reg_rdata_nxt;
    end
  end

  // ==========================================================================
  // element reassembly and forward rearrangement
  for (genvar r = 0; r < 7; r++)
  begin : g_row
    for (genvar c = 0; c < 11; c++)
    begin : g_col
      localparam int K = r * 11 + c;
      localparam int KS = ((r % 2 == 1) ? r - 1 : r) * 11 + c;
      // high half from the pins, low half captured one cycle earlier
      wire [9:0] raw = {elem_in[K * 5 +: 5], lo_r[K * 5 +: 5]};
      wire [9:0] src = {elem_in[KS * 5 +: 5], lo_r[KS * 5 +: 5]};
      // a saturated value stays saturated in both halves so the overflow is not lost
      wire [9:0] half = (src == jet_cluster_pkg::ELEM_SAT) ? src : {1'b0, src[9:1]};
      wire here = fwd_mod && split_en && (fwd_col == 4'(c));
      assign elem_nxt[K * 10 +: 10] = here ? half : raw;
    end
  end

  // low half on the first cycle, whole element on the second
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      lo_r <= '0;
      elem_r <= '0;
      bunch_r <= 1'b0;
    end
    else
    begin
      if (elem_hi_phase)
        elem_r <= elem_nxt;
      else
        lo_r <= elem_in;
      bunch_r <= elem_hi_phase;
    end
  end

  // ==========================================================================
  // cluster sums
  logic [839:0] s2;
  for (genvar r = 0; r < 6; r++)
  begin : g_s2r
    for (genvar c = 0; c < 10; c++)
    begin : g_s2c
      assign s2[(r * 10 + c) * 14 +: 14] = win_sum(elem_r, r, c, 2);
    end
  end

  // ==========================================================================
  // region_of_interest evaluation, two rows of four subregions
  logic [87:0] rec;
  logic [7:0] roi_fwd;
  logic [7:0] roi_found;
  logic [7:0] roi_hits [8];
  for (genvar i = 0; i < 8; i++)
  begin : g_roi
    localparam int R0 = 1 + 2 * (i / 4);
    localparam int C0 = 1 + 2 * (i % 4);
    logic [3:0] lm;
    logic [3:0] q_fwd;
    logic [3:0] q_sat;
    logic [7:0] q_hits [4];
    for (genvar q = 0; q < 4; q++)
    begin : g_pos
      localparam int R = R0 + q / 2;
      localparam int C = C0 + q % 2;
      // the 3x3 and 4x4 windows are computed beside the maximum search
      wire [13:0] c2 = s2[(R * 10 + C) * 14 +: 14];
      wire [13:0] c4 = win_sum(elem_r, R - 1, C - 1, 4);
      wire [55:0] c3 = {win_sum(elem_r, R, C, 3), win_sum(elem_r, R, C - 1, 3),
                        win_sum(elem_r, R - 1, C, 3), win_sum(elem_r, R - 1, C - 1, 3)};
      assign lm[q] = is_lmax(s2, R, C);
      assign q_fwd[q] = fwd_mod && (fwd_col == 4'(C) || fwd_col == 4'(C + 1));
      assign q_sat[q] = (c4 == jet_cluster_pkg::SUM_SAT);
      for (genvar k = 0; k < 8; k++)
      begin : g_crit
        wire [11:0] fc = (k < 4) ? crit_r[8 + (k % 4)] : jet_cluster_pkg::CRIT_RST;
        wire [11:0] cc = q_fwd[q] ? fc : crit_r[k];
        assign q_hits[q][k] = lm[q] && crit_pass(cc, c2, c3, c4);
      end
    end
    // lowest position wins if two maxima share a subregion
    wire [1:0] pos = lm[0] ? 2'h0 : lm[1] ? 2'h1 : lm[2] ? 2'h2 : 2'h3;
    assign roi_found[i] = |lm;
    assign roi_fwd[i] = roi_found[i] && q_fwd[pos];
    assign roi_hits[i] = q_hits[pos];
    // record: position low, then hit bits, then saturation
    assign rec[i * 11 +: 11] = {roi_found[i] && q_sat[pos], q_hits[pos],
                                roi_found[i] ? pos : 2'h0};
  end

  // ==========================================================================
  // multiplicities and merger word
  logic [7:0] cent_bits [8];
  logic [7:0] fwd_bits [4];
  logic [23:0] mult_data;
  for (genvar k = 0; k < 8; k++)
  begin : g_mult
    for (genvar i = 0; i < 8; i++)
    begin : g_cnt
      assign cent_bits[k][i] = roi_hits[i][k] && !roi_fwd[i];
    end
  end
  for (genvar k = 0; k < 4; k++)
  begin : g_fmult
    for (genvar i = 0; i < 8; i++)
    begin : g_fcnt
      assign fwd_bits[k][i] = roi_hits[i][k] && roi_fwd[i];
    end
  end
  // central: 8 x 3 bits; forward module: 8 x 2 central then 4 x 2 forward
  always_comb
  begin
    mult_data = 24'h000000;
    for (int k = 0; k < 8; k++)
    begin
      if (fwd_mod)
        mult_data[k * 2 +: 2] = 2'(mult(cent_bits[k], jet_cluster_pkg::MULT_FWD_MAX));
      else
        mult_data[k * 3 +: 3] = mult(cent_bits[k], jet_cluster_pkg::MULT_CENT_MAX);
    end
    if (fwd_mod)
      for (int k = 0; k < 4; k++)
        mult_data[16 + k * 2 +: 2] = 2'(mult(fwd_bits[k], jet_cluster_pkg::MULT_FWD_MAX));
  end
  // split records by the criteria set each one used
  wire [87:0] cent_rec_nxt;
  wire [87:0] fwd_rec_nxt;
  for (genvar i = 0; i < 8; i++)
  begin : g_split
    assign cent_rec_nxt[i * 11 +: 11] = roi_fwd[i] ? 11'h000 : rec[i * 11 +: 11];
    assign fwd_rec_nxt[i * 11 +: 11] = roi_fwd[i] ? rec[i * 11 +: 11] : 11'h000;
  end
  // results held for a full crossing; odd parity sits in the top of 25 bits
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      merger_word_r <= '0;
      merger_valid_r <= 1'b0;
      cent_rec_r <= '0;
      fwd_rec_r <= '0;
      found_r <= 8'h00;
      sat_any_r <= 1'b0;
    end
    else
    begin
      merger_valid_r <= bunch_r;
      if (bunch_r)
      begin
        merger_word_r <= {~^mult_data, mult_data};
        cent_rec_r <= cent_rec_nxt;
        fwd_rec_r <= fwd_rec_nxt;
        found_r <= roi_found;
        sat_any_r <= |(rec & {8{11'h400}});
      end
    end
  end

  // ==========================================================================
  // region_of_interest serial readout, four streams of 44 data bits plus odd parity
  wire [43:0] st_data [4];
  assign st_data[0] = cent_rec_r[43:0];
  assign st_data[1] = cent_rec_r[87:44];
  assign st_data[2] = fwd_rec_r[43:0];
  assign st_data[3] = fwd_rec_r[87:44];
  wire ro_start = roi_read && ro_state_r == jet_cluster_pkg::RO_IDLE;
  wire ro_last = ro_cnt_r == jet_cluster_pkg::STREAM_LAST;
  // one snapshot per request; a request while shifting is ignored
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ro_state_r <= jet_cluster_pkg::RO_IDLE;
      ro_cnt_r <= 6'h00;
      for (int s = 0; s < 4; s++)
        sh_r[s] <= '0;
      roi_stream_r <= 4'h0;
      roi_stream_valid_r <= 1'b0;
    end
    else
    begin
      case (ro_state_r)
        jet_cluster_pkg::RO_IDLE:
        begin
          roi_stream_r <= 4'h0;
          roi_stream_valid_r <= 1'b0;
          if (ro_start)
          begin
            for (int s = 0; s < 4; s++)
              sh_r[s] <= {~^st_data[s], st_data[s]};
            ro_cnt_r <= 6'h00;
            ro_state_r <= jet_cluster_pkg::RO_SHIFT;
          end
        end
        jet_cluster_pkg::RO_SHIFT:
        begin
          for (int s = 0; s < 4; s++)
          begin
            roi_stream_r[s] <= sh_r[s][0];
            sh_r[s] <= {1'b0, sh_r[s][44:1]};
          end
          roi_stream_valid_r <= 1'b1;
          ro_cnt_r <= ro_cnt_r + 6'h01;
          if (ro_last)
            ro_state_r <= jet_cluster_pkg::RO_IDLE;
        end
        default: ro_state_r <= jet_cluster_pkg::RO_IDLE;
      endcase
    end
  end

  assign reg_rdata = reg_rdata_r;
  assign merger_word = merger_word_r;
  assign merger_valid = merger_valid_r;
  assign roi_stream = roi_stream_r;
  assign roi_stream_valid = roi_stream_valid_r;
endmodule
`default_nettype wire

// >>> jet_cluster_finder_chk.sv
/*
  jet_cluster_finder_chk: port-level assertions for the jet cluster finder.
  Assumes it is bound to the top module and sees nothing but its ports.
*/
`default_nettype none
module jet_cluster_finder_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [384:0] elem_in,
  input wire logic elem_hi_phase,
  input wire logic roi_read,
  input wire logic [4:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [24:0] merger_word,
  input wire logic merger_valid,
  input wire logic [3:0] roi_stream,
  input wire logic roi_stream_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  // ==========================================================================
  // burst trackers
  logic [5:0] run_r;
  logic [3:0] par_r;
  // length and folded parity of the current readout burst, cleared between bursts
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      run_r <= 6'h00;
      par_r <= 4'h0;
    end
    else if (roi_stream_valid)
    begin
      run_r <= run_r + 6'h01;
      par_r <= par_r ^ roi_stream;
    end
    else
    begin
      run_r <= 6'h00;
      par_r <= 4'h0;
    end
  end
  // ==========================================================================
  // assertions
  a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data not zero outside the read answer cycle");
  a_unmapped_zero: assert property (reg_rd && reg_addr > 5'h0D |=> reg_rdata == 16'h0000)
    else $error("unmapped read returned data");
  a_word_pulse: assert property (merger_valid |=> !merger_valid ##1 merger_valid)
    else $error("merger valid not one pulse per crossing");
  a_word_hold: assert property (!merger_valid |-> $stable(merger_word))
    else $error("merger word changed without valid");
  a_word_parity: assert property (merger_valid |-> ^merger_word)
    else $error("merger word parity not odd");
  a_roi_start: assert property ($rose(roi_stream_valid) |-> $past(roi_read, 2))
    else $error("readout started without request two cycles before");
  a_roi_length: assert property ($fell(roi_stream_valid) |-> run_r == 6'h2D)
    else $error("readout burst not 45 cycles");
  a_roi_parity: assert property ($fell(roi_stream_valid) |-> par_r == 4'hF)
    else $error("readout lane parity not odd");
  a_roi_bound: assert property (run_r <= 6'h2D)
    else $error("readout burst too long");
  c_roi: cover property ($rose(roi_stream_valid));
  c_word: cover property (merger_valid && merger_word[23:0] != 24'h000000);
  c_read: cover property (reg_rd ##1 reg_rdata != 16'h0000);
endmodule
`default_nettype wire

// >>> jet_source.sv
/*
  jet_source: upstream input processor model feeding multiplexed jet elements.
  Assumes elems holds 77 ten-bit elements, element k at [10k+9:10k], and one clock.
*/
`default_nettype none
module jet_source (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [769:0] elems,
  output logic [384:0] elem_in,
  output logic elem_hi_phase
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // half-word multiplexer: low half first, so phase leaves reset low
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      elem_hi_phase <= 1'b0;
      elem_in <= 385'h0;
    end
    else
    begin
      elem_hi_phase <= !elem_hi_phase;
      for (int k = 0; k < jet_cluster_pkg::NUM_ELEM; k++)
        elem_in[5*k +: 5] <= elem_hi_phase ? elems[10*k +: 5] : elems[10*k+5 +: 5];
    end
  end
endmodule
`default_nettype wire

// >>> jet_cluster_finder_tb.sv
/*
  jet_cluster_finder_tb: self-checking bench for the jet cluster finder.
  Assumes jet_source feeds the element link and the checker is bound below.
*/
`default_nettype none
module jet_cluster_finder_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, arst_n, roi_read, reg_wr, reg_rd, elem_hi_phase, merger_valid, roi_stream_valid;
  logic [384:0] elem_in;
  logic [769:0] elems;
  logic [4:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, d;
  logic [24:0] merger_word, word;
  logic [3:0] roi_stream;
  int fail_count, n_checks, cycles;
  jet_source jet_source_i (.clk, .arst_n, .elems, .elem_in, .elem_hi_phase);
  jet_cluster_finder jet_cluster_finder_i (.clk, .arst_n, .elem_in, .elem_hi_phase, .roi_read,
    .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .merger_word, .merger_valid,
    .roi_stream, .roi_stream_valid);
  // ==========================================================================
  // clock and hang guard; the whole run needs a few hundred cycles
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      fail_count++;
      $display("[ERR] %0t run did not finish", $time);
      wrap_up();
    end
  end
  // ==========================================================================
  // compare, bus and stimulus helpers
  task automatic chk_reg(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t register got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_word(input logic [24:0] got, input logic [24:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t merger word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_stream(input logic [44:0] got, input logic [44:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("[ERR] %0t readout lane got %h expected %h", $time, got, exp);
    end
  endtask
  function automatic logic [24:0] mk(input logic [23:0] m);
    return {~^m, m};
  endfunction
  function automatic logic [44:0] sp(input logic [43:0] m);
    return {~^m, m};
  endfunction
  // one gap cycle between strobes keeps each strobe to one assignment per step
  task automatic wr(input logic [4:0] a, input logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, output logic [15:0] v);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1;
    v = reg_rdata;
  endtask
  task automatic clr;
    elems <= 770'h0;
    @(posedge clk);
  endtask
  task automatic put(input int r, input int c, input logic [9:0] v);
    elems[10*(r*11+c) +: 10] <= v;
  endtask
  // the word stands between crossings, so a settled sample is enough
  task automatic get_word;
    repeat (8) @(posedge clk);
    #1;
    word = merger_word;
  endtask
  task automatic t_roi(input int lane, input logic [43:0] r0);
    logic [44:0] s [4];
    int n;
    @(posedge clk);
    roi_read <= 1'b1;
    @(posedge clk);
    roi_read <= 1'b0;
    n = 0;
    while (roi_stream_valid !== 1'b1 && n < 8)
    begin
      @(posedge clk);
      #1;
      n++;
    end
    for (int b = 0; b < 45; b++)
    begin
      for (int l = 0; l < 4; l++)
        s[l][b] = roi_stream[l];
      @(posedge clk);
      #1;
    end
    chk_stream(s[lane], sp(r0));
    for (int l = 0; l < 4; l++)
      if (l != lane)
        chk_stream(s[l], sp(44'h0));
  endtask
  // ==========================================================================
  // scenarios
  task automatic t_regs;
    for (int i = 0; i < 12; i++)
    begin
      rd(5'(i), d);
      chk_reg(d, 16'h03FF);
    end
    clr;
    put(2, 2, 10'h300);
    get_word;
    chk_word(word, mk(24'h000000));
    wr(5'h0C, 16'hFFFF);
    rd(5'h0C, d);
    chk_reg(d, 16'h0007);
    rd(5'h1F, d);
    chk_reg(d, 16'h0000);
    wr(5'h0C, 16'h0000);
  endtask
  // one jet hits the 2x2, 3x3 and 4x4 size codes; a threshold equal to the sum must not pass
  task automatic t_single;
    wr(5'h00, 16'h00FF);
    wr(5'h01, 16'h08FF);
    wr(5'h02, 16'h04FF);
    wr(5'h03, 16'h0100);
    wr(5'h04, 16'h0C00);
    clr;
    put(2, 2, 10'h100);
    get_word;
    chk_word(word, mk(24'h000049));
    t_roi(0, 44'h01F);
  endtask
  // eight subregion maxima overflow both multiplicity widths
  task automatic t_clamp;
    clr;
    for (int r = 2; r <= 4; r += 2)
      for (int c = 2; c <= 8; c += 2)
        put(r, c, 10'(1008 - 8*(r*11+c)));
    get_word;
    chk_word(word, mk(24'h000FFF));
    wr(5'h0C, 16'h0001);
    get_word;
    chk_word(word, mk(24'h0000FF));
  endtask
  task automatic t_fwd;
    wr(5'h08, 16'h00FF);
    clr;
    put(2, 1, 10'h180);
    get_word;
    chk_word(word, mk(24'h010000));
    wr(5'h0C, 16'h0003);
    get_word;
    chk_word(word, mk(24'h000055));
    wr(5'h0C, 16'h0005);
    wr(5'h08, 16'h0200);
    wr(5'h09, 16'h01FF);
    clr;
    put(2, 1, 10'h200);
    put(3, 1, 10'h3F0);
    get_word;
    chk_word(word, mk(24'h040000));
    t_roi(2, 44'h00A);
  endtask
  task automatic t_sat;
    wr(5'h0C, 16'h0000);
    clr;
    put(2, 2, 10'h3FF);
    get_word;
    rd(5'h0D, d);
    chk_reg(d, 16'h4001);
    t_roi(0, 44'h43F);
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // ==========================================================================
  // main sequence
  initial
  begin
    arst_n = 1'b0;
    roi_read = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 5'h00;
    reg_wdata = 16'h0000;
    elems = 770'h0;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    t_regs;
    t_single;
    t_clamp;
    t_fwd;
    t_sat;
    wrap_up();
  end
endmodule
bind jet_cluster_finder jet_cluster_finder_chk jet_cluster_finder_chk_i (.clk, .arst_n,
  .elem_in, .elem_hi_phase, .roi_read, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
  .merger_word, .merger_valid, .roi_stream, .roi_stream_valid);
`default_nettype wire
